// ===== apsr_params.svh
/*
 * constants of the arbitrary pulse sample ram: register offsets, field positions,
 * reset values and template figures.
 * assumes a host port with one-cycle strobes and read data one cycle later.
 */
`ifndef APSR_PARAMS_SVH
`define APSR_PARAMS_SVH
`define APSR_ADDR_W        4
`define APSR_OFF_SHAPE     4'h0
`define APSR_OFF_INDEX     4'h1
`define APSR_OFF_LEVEL     4'h2
`define APSR_OFF_ACCESS    4'h3
`define APSR_OFF_GAIN      4'h4
`define APSR_OFF_STATUS    4'h5
`define APSR_OFF_ROMSEL    4'h6
`define APSR_ACC_DIR_BIT   0
`define APSR_ACC_TRIG_BIT  1
`define APSR_ACC_LOAD_BIT  2
`define APSR_USER_SHAPE    2'h3
`define APSR_GAIN_RST      6'h21
`define APSR_E1_75_GAIN    6'h21
`define APSR_E1_75_STEP    8'h03
`define APSR_E1_75_EDGE    7'h0c
`define APSR_E1_75_BODY    7'h30
`define APSR_E1_120_GAIN   6'h21
`define APSR_T1_SHORT_GAIN 6'h36
`define APSR_ROM_COUNT     4'hc
`endif

// ===== apsr_pkg.sv
/*
 * types of the arbitrary pulse sample ram.
 * assumes apsr_params.svh is on the include path.
 */
package apsr_pkg;
  typedef enum logic [1:0] {
    APSR_IDLE = 2'b00,
    APSR_XFER = 2'b01,
    APSR_LOAD = 2'b10
  } apsr_state_t;
endpackage : apsr_pkg

// ===== apsr_sample_ram.sv
/*
 * transmit pulse sample store: 64-entry ram with indirect access, template rom,
 * gain code and registered, unscaled output sample for the shaper.
 * assumes a host that keeps strobes one cycle and one access at a time.
 */
`include "apsr_params.svh"

module apsr_sample_ram
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [5:0]  shape_addr,
  output logic             user_shape_sel,
  output logic             gain_apply,
  output logic      [6:0]  shape_sample,
  output logic      [5:0]  shape_gain
);
  import apsr_pkg::*;

  // ************************************************************
  // template rom
  // ************************************************************
  // slots 0 to 2 hold e1 75 ohm, e1 120 ohm and the shortest t1 shape;
  // the remaining slots read as zero, so loading slots 3 to 11 clears the ram; slots 12 to 15 start no load
  function automatic logic [6:0] rom_sample(input logic [3:0] sel, input logic [5:0] a);
    logic [6:0] v;
    v = 7'h00;
    case (sel)
      4'h0:
      begin
        if (a[5:4] == 2'h0)
        begin
          if (a[3:0] == 4'h3)
            v = `APSR_E1_75_EDGE;
          else if (a[3:0] >= 4'h4 && a[3:0] <= 4'hb)
            v = `APSR_E1_75_BODY;
        end
      end
      4'h1:
      begin
        if (a[5:4] == 2'h0)
        begin
          if (a[3:0] == 4'h3)
            v = 7'h0f;
          else if (a[3:0] >= 4'h4 && a[3:0] <= 4'hb)
            v = 7'h3c;
        end
      end
      4'h2:
      begin
        case (a)
          6'h00:   v = 7'h17;
          6'h01:   v = 7'h27;
          6'h02:   v = 7'h27;
          6'h03:   v = 7'h26;
          6'h04:   v = 7'h25;
          6'h05:   v = 7'h25;
          6'h06:   v = 7'h25;
          6'h07:   v = 7'h24;
          6'h08:   v = 7'h23;
          6'h09:   v = 7'h4a;
          6'h0a:   v = 7'h4a;
          6'h0b:   v = 7'h49;
          6'h0c:   v = 7'h47;
          6'h0d:   v = 7'h45;
          6'h0e:   v = 7'h44;
          6'h0f:   v = 7'h43;
          6'h10:   v = 7'h42;
          6'h11:   v = 7'h41;
          default: v = 7'h00;
        endcase
      end
      default: v = 7'h00;
    endcase
    return v;
  endfunction : rom_sample

  function automatic logic [5:0] rom_gain(input logic [3:0] sel);
    logic [5:0] g;
    case (sel)
      4'h0:    g = `APSR_E1_75_GAIN;
      4'h1:    g = `APSR_E1_120_GAIN;
      4'h2:    g = `APSR_T1_SHORT_GAIN;
      default: g = `APSR_GAIN_RST;
    endcase
    return g;
  endfunction : rom_gain

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [3:0]  shape;
    logic [1:0]  ui;
    logic [3:0]  phase;
    logic [6:0]  level;
    logic        dir;
    logic        trig;
    logic [5:0]  gain;
    logic [3:0]  romsel;
    logic [5:0]  load_cnt;
    apsr_state_t st;
    logic [7:0]  rdata;
    logic [6:0]  sample;
  } apsr_regs_t;

  apsr_regs_t q, d;
  logic [6:0] mem [0:63];
  logic       mem_we;
  logic [5:0] mem_wa;
  logic [6:0] mem_wd;
  logic [5:0] acc_addr;

  assign acc_addr = {q.ui, q.phase};

  always_comb
  begin
    d      = q;
    mem_we = 1'b0;
    mem_wa = acc_addr;
    mem_wd = q.level;
    d.rdata = 8'h00;
    if (reg_wr)
    begin
      case (reg_addr)
        `APSR_OFF_SHAPE:  d.shape = reg_wdata[3:0];
        `APSR_OFF_INDEX:
        begin
          d.ui    = reg_wdata[5:4];
          d.phase = reg_wdata[3:0];
        end
        `APSR_OFF_LEVEL:  d.level = reg_wdata[6:0];
        `APSR_OFF_ACCESS:
        begin
          if (q.st == APSR_IDLE)
          begin
            d.dir = reg_wdata[`APSR_ACC_DIR_BIT];
            if (reg_wdata[`APSR_ACC_LOAD_BIT] && reg_wdata[3:0] != 4'h0 && q.romsel < `APSR_ROM_COUNT)
            begin
              d.trig     = 1'b1;
              d.load_cnt = 6'h00;
              d.st       = APSR_LOAD;
            end
            else if (reg_wdata[`APSR_ACC_TRIG_BIT])
            begin
              d.trig = 1'b1;
              d.st   = APSR_XFER;
            end
          end
        end
        `APSR_OFF_GAIN:   d.gain = reg_wdata[5:0];
        `APSR_OFF_ROMSEL: d.romsel = reg_wdata[3:0];
        default:          d.shape = q.shape;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `APSR_OFF_SHAPE:  d.rdata = {4'h0, q.shape};
        `APSR_OFF_INDEX:  d.rdata = {2'h0, q.ui, q.phase};
        `APSR_OFF_LEVEL:  d.rdata = {1'b0, q.level};
        `APSR_OFF_ACCESS: d.rdata = {6'h00, q.trig, q.dir};
        `APSR_OFF_GAIN:   d.rdata = {2'h0, q.gain};
        `APSR_OFF_STATUS: d.rdata = {6'h00, q.st};
        `APSR_OFF_ROMSEL: d.rdata = {4'h0, q.romsel};
        default:          d.rdata = 8'h00;
      endcase
    end
    case (q.st)
      APSR_IDLE: d.st = d.st;
      APSR_XFER:
      begin
        if (!q.dir)
          mem_we = 1'b1;
        else
          d.level = mem[acc_addr];
        d.trig = 1'b0;
        d.st   = APSR_IDLE;
      end
      APSR_LOAD:
      begin
        // copies the selected template in, one sample per cycle
        mem_we = 1'b1;
        mem_wa = q.load_cnt;
        mem_wd = rom_sample(q.romsel, q.load_cnt);
        d.load_cnt = q.load_cnt + 6'h01;
        if (q.load_cnt == 6'h3f)
        begin
          d.gain = rom_gain(q.romsel);
          d.trig = 1'b0;
          d.st   = APSR_IDLE;
        end
      end
      default: d.st = APSR_IDLE;
    endcase
    d.sample = mem[shape_addr];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q        <= '0;
      q.gain   <= `APSR_GAIN_RST;
      q.st     <= APSR_IDLE;
    end
    else
      q <= d;
  end

  // ram has no reset: contents stay undefined until written or loaded
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign reg_rdata      = q.rdata;
  assign user_shape_sel = (q.shape[3:2] == `APSR_USER_SHAPE);
  assign gain_apply     = user_shape_sel;
  assign shape_sample   = q.sample;
  assign shape_gain     = q.gain;
endmodule : apsr_sample_ram

// ===== apsr_sample_ram_chk.sv
/* checker of the pulse sample ram ports.
   assumes one clock domain and reads answered one cycle after the strobe. */
module apsr_sample_ram_chk
(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       user_shape_sel,
  input wire logic       gain_apply,
  input wire logic [5:0] shape_gain
);
  // ****************
  // port relations
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_user_shape_on: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[3:2] == 2'b11 |=> user_shape_sel)
    else $error("user shape not selected");
  a_user_shape_off: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[3:2] != 2'b11 |=> !user_shape_sel)
    else $error("user shape selected wrongly");
  a_scale_user_only: assert property (gain_apply == user_shape_sel)
    else $error("scaling outside user shape");
  a_gain_write: assert property (reg_wr && reg_addr == 4'h4 |=> shape_gain == $past(reg_wdata[5:0]))
    else $error("gain code not taken");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_trig_cleared: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata[1] && !reg_wdata[2]
    ##2 reg_rd && reg_addr == 4'h3 |=> !reg_rdata[1])
    else $error("trigger still set");
  a_shape_readback: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
    else $error("shape choice read back wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_load: cover property (reg_wr && reg_addr == 4'h3 && reg_wdata[2]);
  c_user: cover property ($rose(user_shape_sel));
  c_level_rd: cover property (reg_rd && reg_addr == 4'h2);
endmodule : apsr_sample_ram_chk

bind apsr_sample_ram apsr_sample_ram_chk u_apsr_sample_ram_chk (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .user_shape_sel, .gain_apply, .shape_gain);

// ===== apsr_sample_ram_tb.sv
/* bench of the pulse sample ram: host tasks, sample round trips, template load.
   assumes apsr_params.svh on the include path. */
`include "apsr_params.svh"
module apsr_sample_ram_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, user_shape_sel, gain_apply;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [5:0] shape_addr = 0, shape_gain;
  logic [6:0] shape_sample;
  int         error_cnt = 0, num_checks = 0, i;
  always #2 mclk = ~mclk;
  apsr_sample_ram u_apsr_sample_ram (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shape_addr, .user_shape_sel, .gain_apply, .shape_sample, .shape_gain);
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rd
  task spl(input logic [5:0] a, input logic [6:0] e);
    @(posedge mclk);
    shape_addr <= a;
    @(posedge mclk);
    #1 chk("sample", {1'b0, shape_sample}, {1'b0, e});
  endtask : spl
  // sign bit chosen so both +63 and negative values occur
  function automatic logic [6:0] lv(input logic [5:0] a);
    return {a[0] ^ a[1], a};
  endfunction : lv
  task test_done;
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial
  begin
    #40000;
    error_cnt++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(`APSR_OFF_GAIN, 8'h21, "gain_rst");
    for (i = 0; i < 16; i++)
    begin
      wr(`APSR_OFF_SHAPE, 8'(i));
      #1 chk("shape_sel", {7'h00, user_shape_sel}, {7'h00, i[3:2] == 2'b11});
      chk("gain_apply", {7'h00, gain_apply}, {7'h00, i[3:2] == 2'b11});
    end
    for (i = 0; i < 64; i++)
    begin
      wr(`APSR_OFF_INDEX, 8'(i));
      wr(`APSR_OFF_LEVEL, {1'b0, lv(i[5:0])});
      wr(`APSR_OFF_ACCESS, 8'h02);
    end
    for (i = 0; i < 64; i++)
    begin
      wr(`APSR_OFF_INDEX, 8'(i));
      wr(`APSR_OFF_LEVEL, 8'h00);
      wr(`APSR_OFF_ACCESS, 8'h03);
      rd(`APSR_OFF_ACCESS, 8'h01, "trig");
      rd(`APSR_OFF_LEVEL, {1'b0, lv(i[5:0])}, "level");
      spl(i[5:0], lv(i[5:0]));
    end
    // a slot past the rom must not start a load
    wr(`APSR_OFF_ROMSEL, 8'h0c);
    wr(`APSR_OFF_ACCESS, 8'h04);
    rd(`APSR_OFF_STATUS, 8'h00, "status");
    wr(`APSR_OFF_ROMSEL, 8'h00);
    wr(`APSR_OFF_GAIN, 8'h05);
    #1 chk("gain_out", {2'h0, shape_gain}, 8'h05);
    wr(`APSR_OFF_ACCESS, 8'h04);
    repeat (70) @(posedge mclk);
    rd(`APSR_OFF_GAIN, 8'h21, "tmpl_gain");
    chk("tmpl_gain_out", {2'h0, shape_gain}, 8'h21);
    for (i = 0; i < 64; i++)
      spl(i[5:0], i[5:4] != 0 ? 7'h00 : i[3:0] == 3 ? 7'h0c : (i[3:0] > 3 && i[3:0] < 12) ? 7'h30 : 7'h00);
    rd(4'hf, 8'h00, "unmapped");
    test_done;
  end
endmodule : apsr_sample_ram_tb
